// ### design/lfm_link_monitor.sv
// Per-channel signal detect, range control and link fault logic
`timescale 1ns/1ns
module lfm_link_monitor
   import lfm_pkg::*;
#(
   parameter int QUIET_BITS   = QUIET_LIMIT_BITS,
   parameter int RANGE_CHARS  = RANGE_PERIOD_CHARS,
   parameter int FORCE_CHARS  = 16,
   parameter int SETTLE_CHARS = 16
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       bitTick,
   input  wire logic       charTick,
   input  wire logic       dataTransition,
   input  wire logic [1:0] amplitudeThresholdSelect,
   input  wire logic [1:0] amplitudeLevelPrimary,
   input  wire logic [1:0] amplitudeLevelSecondary,
   input  wire logic       inputPortSelect,
   input  wire logic [1:0] speedRangeSelect,
   input  wire logic       trainingClockRate,
   input  wire logic       freqDeviationOk,
   input  wire logic       receiveChannelPower,
   input  wire logic       referenceClockPresent,
   input  wire logic       forcedFaultControl,
   output logic            oscillatorForce,
   output logic            primarySelected,
   output logic            rateConfigReserved,
   output logic            linkFaultIndicator
);
   localparam int RW = $clog2(RANGE_CHARS + 1);
   localparam int QW = $clog2(QUIET_BITS + 2);

   ////////////////////////////////////////////////////////////////
   // Amplitude compare; selected level code must reach threshold
   function automatic logic ampOk(input logic [1:0] sel, input logic [1:0] lvl);
      ampOk = (sel == AMP_SEL_OFF) ? 1'b1 : (lvl >= sel);
   endfunction : ampOk

   logic [1:0] selLevel;
   logic       ampValid;
   // Route only the chosen receiver into the amplitude check
   assign primarySelected = inputPortSelect;
   assign selLevel = inputPortSelect ? amplitudeLevelPrimary
                                     : amplitudeLevelSecondary;
   // Threshold is a shared device-level input, fed to each channel
   assign ampValid = ampOk(amplitudeThresholdSelect, selLevel);

   // Half rate at the lowest speed is a reserved training setting
   assign rateConfigReserved = (speedRangeSelect == SPD_LOW) &&
                               trainingClockRate;

   ////////////////////////////////////////////////////////////////
   // Transition density: bit-time run length since last edge
   logic [QW-1:0] quiet_q;
   logic          quietFault;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         quiet_q <= '0;
      end else if (dataTransition) begin
         quiet_q <= '0;
      end else if (bitTick && (quiet_q <= QW'(QUIET_BITS))) begin
         quiet_q <= quiet_q + 1'b1;
      end
   end
   // Strictly more than sixty bits quiet raises the fault
   assign quietFault = (quiet_q > QW'(QUIET_BITS));

   ////////////////////////////////////////////////////////////////
   // Range control: sample window, force phase, settle phase
   lfm_rc_state_t state_q;
   logic [RW-1:0] winCount;
   logic          winClear;
   logic          winDone;
   logic          freqBad_q;

   lfm_window_counter #(
      .WIDTH (RW)
   ) uWindow (
      .clk   (clk),
      .rstn  (rstn),
      .clear (winClear),
      .tick  (charTick),
      .count (winCount),
      .ovf   ()
   );

   // Interval end at 4096 character clocks
   assign winDone = charTick && (winCount == RW'(RANGE_CHARS - 1));

   // Sticky deviation flag over the window; a late miss still counts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         freqBad_q <= 1'b0;
      end else if (winClear) begin
         freqBad_q <= !freqDeviationOk;
      end else if (!freqDeviationOk) begin
         freqBad_q <= 1'b1;
      end
   end

   // Window restarts at every interval end and phase change
   always_comb begin
      winClear = 1'b0;
      case (state_q)
         RC_SAMPLE: winClear = winDone;
         RC_FORCE:  winClear = charTick && (winCount == RW'(FORCE_CHARS - 1));
         RC_SETTLE: winClear = charTick && (winCount == RW'(SETTLE_CHARS - 1));
         default:   winClear = 1'b1;
      endcase
      // Powered-down channel holds the window at its start, so no short first window
      if (!receiveChannelPower) begin
         winClear = 1'b1;
      end
   end

   // State sequence; unpowered channel holds in sampling
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= RC_SAMPLE;
      end else if (!receiveChannelPower) begin
         state_q <= RC_SAMPLE;
      end else begin
         case (state_q)
            RC_SAMPLE: if (winDone && (freqBad_q || !freqDeviationOk)) begin
               state_q <= RC_FORCE;
            end
            RC_FORCE:  if (winClear) begin
               state_q <= RC_SETTLE;
            end
            RC_SETTLE: if (winClear) begin
               state_q <= RC_SAMPLE;
            end
            default:   state_q <= RC_SAMPLE;
         endcase
      end
   end

   assign oscillatorForce = (state_q == RC_FORCE);

   ////////////////////////////////////////////////////////////////
   // Combined indicator, registered on the receive clock
   logic allValid;
   assign allValid = ampValid && !quietFault && freqDeviationOk &&
                     receiveChannelPower && referenceClockPresent &&
                     !forcedFaultControl && (state_q == RC_SAMPLE);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         linkFaultIndicator <= LFI_RESET;
      end else begin
         linkFaultIndicator <= allValid;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   // Worst lock: a stale miss finishes its window, then force and settle run
   localparam int LOCK_TICKS = RANGE_CHARS + FORCE_CHARS + SETTLE_CHARS + 1;
   logic        extValid;
   int unsigned lockWait;
   int unsigned ivlTicks;
   assign extValid = ampValid && !quietFault && freqDeviationOk && receiveChannelPower &&
                     referenceClockPresent && !forcedFaultControl;
   // Character ticks spent low while every outside check already passes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lockWait <= 0;
      end else if (linkFaultIndicator || !extValid) begin
         lockWait <= 0;
      end else if (charTick) begin
         lockWait <= lockWait + 1;
      end
   end

   // Own tick count since the sampling window opened, kept apart from the counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ivlTicks <= 0;
      end else if ((state_q != RC_SAMPLE) || !receiveChannelPower) begin
         ivlTicks <= 0;
      end else if (charTick) begin
         ivlTicks <= (ivlTicks == RANGE_CHARS - 1) ? 0 : ivlTicks + 1;
      end
   end

   sequence forceSeq;
      (state_q == RC_FORCE);
   endsequence

   all_valid_a: assert property (@(posedge clk) disable iff (!rstn)
      linkFaultIndicator |-> $past(freqDeviationOk && referenceClockPresent &&
                                   !forcedFaultControl && ampValid))
      else $error("Indicator high without all checks valid");
   sync_update_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (linkFaultIndicator == $past(allValid)))
      else $error("Indicator not registered from combined check");
   thresh_off_a: assert property (@(posedge clk) disable iff (!rstn)
      (amplitudeThresholdSelect == AMP_SEL_OFF) |-> ampValid)
      else $error("Disabled detector blocked signal");
   port_route_a: assert property (@(posedge clk) disable iff (!rstn)
      ((inputPortSelect && (amplitudeLevelPrimary < amplitudeThresholdSelect)) ||
       (!inputPortSelect && (amplitudeLevelSecondary < amplitudeThresholdSelect)))
      |-> !ampValid)
      else $error("Amplitude taken from wrong receiver");
   quiet_fault_a: assert property (@(posedge clk) disable iff (!rstn)
      (quiet_q > QW'(QUIET_BITS)) |=> !linkFaultIndicator)
      else $error("Quiet line did not raise fault");
   quiet_restart_a: assert property (@(posedge clk) disable iff (!rstn)
      dataTransition |=> (quiet_q == '0))
      else $error("Quiet counter did not restart");
   force_low_a: assert property (@(posedge clk) disable iff (!rstn)
      forceSeq ##1 forceSeq |-> !linkFaultIndicator)
      else $error("Indicator high while oscillator forced");
   power_fault_a: assert property (@(posedge clk) disable iff (!rstn)
      !receiveChannelPower ##1 !receiveChannelPower |-> !linkFaultIndicator)
      else $error("Powered down channel shows valid");
   window_len_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RC_SAMPLE && receiveChannelPower && charTick)
      |-> (winDone == (ivlTicks == RANGE_CHARS - 1)))
      else $error("Sampling interval length wrong");
   force_entry_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RC_SAMPLE && winDone && receiveChannelPower && !freqDeviationOk)
      |=> oscillatorForce)
      else $error("Deviation did not force oscillator");
   lock_bound_a: assert property (@(posedge clk) disable iff (!rstn)
      (lockWait <= LOCK_TICKS))
      else $error("Lock took longer than one interval plus relock");
endmodule : lfm_link_monitor

// ### shared/lfm_pkg.sv
// Shared constants and types for the link fault range monitor
package lfm_pkg;
   // Amplitude threshold select codes
   localparam logic [1:0] AMP_SEL_OFF  = 2'h0;
   localparam logic [1:0] AMP_SEL_LOW  = 2'h1;
   localparam logic [1:0] AMP_SEL_MID  = 2'h2;
   localparam logic [1:0] AMP_SEL_HIGH = 2'h3;
   // Speed range select codes
   localparam logic [1:0] SPD_LOW  = 2'h0;
   localparam logic [1:0] SPD_MID  = 2'h1;
   localparam logic [1:0] SPD_HIGH = 2'h2;
   // Transition density: bits per character and characters allowed quiet
   localparam int BITS_PER_CHAR     = 10;
   localparam int QUIET_CHARS       = 6;
   localparam int QUIET_LIMIT_BITS  = BITS_PER_CHAR * QUIET_CHARS;
   localparam int QUIET_LIMIT_CHARS = QUIET_CHARS;
   // Range control sampling interval in recovered character clocks
   localparam int RANGE_PERIOD_CHARS = 4096;
   // Frequency window in ppm
   localparam int RANGE_PPM = 1500;
   // Reset values
   localparam logic LFI_RESET = 1'b0;
   // Range control states
   typedef enum logic [2:0] {
      RC_SAMPLE = 3'b001,
      RC_FORCE  = 3'b010,
      RC_SETTLE = 3'b100
   } lfm_rc_state_t;
endpackage : lfm_pkg

// ### design/lfm_window_counter.sv
// Counter of one-cycle tick pulses forming a sampling window
`timescale 1ns/1ns
module lfm_window_counter
   import lfm_pkg::*;
#(
   parameter int WIDTH = 13
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             clear,
   input  wire logic             tick,
   output logic      [WIDTH-1:0] count,
   output logic                  ovf
);
   ////////////////////////////////////////////////////////////////
   // Saturating counter; clear wins so a restart is never missed
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (tick && !ovf) begin
         count <= count + 1'b1;
      end
   end

   // Overflow flags a full count
   assign ovf = &count;
endmodule : lfm_window_counter

// ### test/lfm_serial_source.sv
// Far-end serial source model: bit and character ticks plus transitions
`timescale 1ns/1ns
module lfm_serial_source (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic quiet,
   output logic      bitTick,
   output logic      charTick,
   output logic      dataTransition
);
   logic [3:0] bitCnt_q;
   logic [1:0] edgeCnt_q;
   // Steady stream of one bit per cycle, ten bits per character
   assign bitTick        = rstn;
   assign charTick       = rstn && (bitCnt_q == 4'h9);
   // Edge every third bit; a quiet line keeps ticking but never toggles
   assign dataTransition = rstn && !quiet && (edgeCnt_q == 2'h2);
   // Bit and edge position counters
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bitCnt_q  <= 4'h0;
         edgeCnt_q <= 2'h0;
      end else begin
         bitCnt_q  <= (bitCnt_q == 4'h9) ? 4'h0 : bitCnt_q + 4'h1;
         edgeCnt_q <= (edgeCnt_q == 2'h2) ? 2'h0 : edgeCnt_q + 2'h1;
      end
   end
endmodule : lfm_serial_source

// ### test/tb_lfm_link_monitor.sv
// Self-checking bench for the link monitor with a far-end source model
`timescale 1ns/1ns
module tb_lfm_link_monitor;
   import lfm_pkg::*;
   typedef struct packed {
      logic [1:0] thr, lvlP, lvlS;
      logic       sel, pwr, refOk, ff;
      logic [1:0] spd;
      logic       rate, lfi, rsv;
   } lfm_row_t;
   // thr lvlP lvlS sel pwr ref ff spd rate -> indicator reserved
   localparam lfm_row_t ROWS [10] = '{
      '{2'h1, 2'h1, 2'h0, 1'h1, 1'h1, 1'h1, 1'h0, SPD_MID, 1'h0, 1'h1, 1'h0},
      '{2'h2, 2'h1, 2'h3, 1'h1, 1'h1, 1'h1, 1'h0, SPD_MID, 1'h0, 1'h0, 1'h0},
      '{2'h2, 2'h1, 2'h3, 1'h0, 1'h1, 1'h1, 1'h0, SPD_MID, 1'h1, 1'h1, 1'h0},
      '{2'h3, 2'h2, 2'h3, 1'h1, 1'h1, 1'h1, 1'h0, SPD_HIGH, 1'h0, 1'h0, 1'h0},
      '{2'h0, 2'h0, 2'h0, 1'h1, 1'h1, 1'h1, 1'h0, SPD_LOW, 1'h1, 1'h1, 1'h1},
      '{2'h3, 2'h3, 2'h0, 1'h1, 1'h0, 1'h1, 1'h0, SPD_LOW, 1'h0, 1'h0, 1'h0},
      '{2'h3, 2'h3, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0, SPD_MID, 1'h0, 1'h0, 1'h0},
      '{2'h3, 2'h3, 2'h0, 1'h1, 1'h1, 1'h1, 1'h1, SPD_MID, 1'h0, 1'h0, 1'h0},
      '{2'h1, 2'h0, 2'h3, 1'h1, 1'h1, 1'h1, 1'h0, SPD_LOW, 1'h0, 1'h0, 1'h0},
      '{2'h3, 2'h3, 2'h0, 1'h1, 1'h1, 1'h1, 1'h0, SPD_HIGH, 1'h1, 1'h1, 1'h0}
   };
   logic       clk, rstn, quiet, sel, rate, freqOk, pwr, refOk, ff;
   logic [1:0] thr, lvlP, lvlS, spd;
   logic       bitTick, charTick, dataTransition, oscForce, primSel, rsv, lfi;
   int         n_errors, comparisons;
   ////////////////////////////////////////////////////////////////////////////
   // Far end and device; short range counts keep the run brief
   lfm_serial_source u_lfm_serial_source (.clk(clk), .rstn(rstn), .quiet(quiet),
      .bitTick(bitTick), .charTick(charTick), .dataTransition(dataTransition));
   lfm_link_monitor #(.RANGE_CHARS(16), .FORCE_CHARS(4), .SETTLE_CHARS(4))
   u_lfm_link_monitor (.clk(clk), .rstn(rstn), .bitTick(bitTick), .charTick(charTick),
      .dataTransition(dataTransition), .amplitudeThresholdSelect(thr),
      .amplitudeLevelPrimary(lvlP), .amplitudeLevelSecondary(lvlS),
      .inputPortSelect(sel), .speedRangeSelect(spd), .trainingClockRate(rate),
      .freqDeviationOk(freqOk), .receiveChannelPower(pwr),
      .referenceClockPresent(refOk), .forcedFaultControl(ff),
      .oscillatorForce(oscForce), .primarySelected(primSel),
      .rateConfigReserved(rsv), .linkFaultIndicator(lfi));
   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers; checks land on the falling edge, after updates settle
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic waitFor(ref logic sig, input logic val, input int lim);
      for (int k = 0; k < lim && sig !== val; k++) @(negedge clk);
   endtask : waitFor
   task automatic chk(input logic got, input logic exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the tests need about 270 cycles
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial begin
      #500000;
      n_errors++;
      tally_and_finish();
   end
   // Main sequence: reset, table, then quiet line and range control
   initial begin
      {quiet, thr, lvlP, lvlS, sel, spd, rate, pwr, refOk, ff} <= '0;
      freqOk <= 1'h1;
      rstn <= 1'h0;
      settle(10);
      chk(lfi, 1'h0, "reset indicator");
      chk(oscForce, 1'h0, "reset force");
      @(posedge clk) rstn <= 1'h1;
      foreach (ROWS[i]) begin
         @(posedge clk) {thr, lvlP, lvlS, sel, pwr, refOk, ff, spd, rate} <= ROWS[i][14:2];
         settle(3);
         chk(lfi, ROWS[i].lfi, "table indicator");
         chk(primSel, ROWS[i].sel, "table port");
         chk(rsv, ROWS[i].rsv, "table rate");
      end
      // Two edges between quiet spans must restart the count
      @(posedge clk) quiet <= 1'h1;
      settle(50);
      chk(lfi, 1'h1, "short quiet");
      @(posedge clk) quiet <= 1'h0;
      settle(4);
      @(posedge clk) quiet <= 1'h1;
      settle(50);
      chk(lfi, 1'h1, "restarted quiet");
      settle(20);
      chk(lfi, 1'h0, "long quiet");
      @(posedge clk) quiet <= 1'h0;
      settle(5);
      chk(lfi, 1'h1, "edges back");
      // Deviation over one window forces, then settles and relocks
      @(posedge clk) freqOk <= 1'h0;
      waitFor(oscForce, 1'h1, 200);
      chk(oscForce, 1'h1, "force on deviation");
      @(posedge clk) freqOk <= 1'h1;
      settle(1);
      chk(lfi, 1'h0, "indicator while forced");
      waitFor(oscForce, 1'h0, 100);
      chk(lfi, 1'h0, "indicator after force");
      waitFor(lfi, 1'h1, 200);
      chk(lfi, 1'h1, "relock");
      tally_and_finish();
   end
endmodule : tb_lfm_link_monitor
